// *** src/ttp_pkg.sv ***
// Constants, register map and mode encoding for the triple timer block
package ttp_pkg;

  // Register map, byte addresses
  localparam int           ADDR_W       = 8;
  localparam int           NUM_CH       = 3;
  localparam logic [7:0]   CH_STRIDE    = 8'h10;
  localparam logic [7:0]   OFS_CTL      = 8'h00;
  localparam logic [7:0]   OFS_LOAD     = 8'h04;
  localparam logic [7:0]   OFS_CMP      = 8'h08;
  localparam logic [7:0]   OFS_CNT      = 8'h0c;
  localparam logic [7:0]   OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0]   OFS_IRQ_MASK = 8'h34;

  // Control and status field positions
  localparam int           CTL_EN       = 0;
  localparam int           CTL_MODE_LSB = 1;
  localparam int           CTL_MODE_W   = 3;
  localparam int           CTL_EXT_CLK  = 4;
  localparam int           CTL_GPIO_DIR = 5;
  localparam int           CTL_GPIO_VAL = 6;
  localparam int           CTL_W        = 7;
  localparam int           STAT_PIN     = 16;
  localparam int           STAT_OE      = 17;

  // Reset values
  localparam logic [6:0]   CTL_RST      = 7'h00;
  localparam logic [31:0]  WORD_RST     = 32'h0000_0000;
  localparam logic [2:0]   IRQ_RST      = 3'h0;

  // Counter width
  localparam int           CNT_W        = 32;

  // Bus responses
  localparam logic [1:0]   RESP_OKAY    = 2'h0;
  localparam logic [1:0]   RESP_SLVERR  = 2'h2;

  // Channel modes; unused codes count but raise no hit and leave the pin an undriven input
  typedef enum logic [2:0] {
    MD_GPIO,
    MD_TIMER,
    MD_PWM,
    MD_WDOG,
    MD_EVENT,
    MD_MEAS
  } ttp_mode_t;

endpackage : ttp_pkg

// *** src/ttp_channel.sv ***
// One timer channel: counter, compare, capture and pin direction logic
module ttp_channel
  import ttp_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Processor state
  input  wire logic             stop,
  // Configuration
  input  wire logic [CTL_W-1:0] ctl,
  input  wire logic [CNT_W-1:0] loadVal,
  input  wire logic [CNT_W-1:0] cmpVal,
  // Synchronised pin level
  input  wire logic             pinLvl,
  // Results
  output logic      [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] capture,
  output logic                  hit,
  output logic                  pinOut,
  output logic                  pinOe
);

  ttp_mode_t  mode;
  logic       run;
  logic       pinPrev;
  logic       rise;
  logic       fall;
  logic       tick;
  logic       reload;
  logic       hitNxt;

  assign mode = ttp_mode_t'(ctl[CTL_MODE_LSB +: CTL_MODE_W]);
  // Stop freezes counting and ignores the pin  see R9
  assign run  = ctl[CTL_EN] & ~stop;
  assign rise = pinLvl & ~pinPrev;
  assign fall = ~pinLvl & pinPrev;

  always_comb begin
    // Internal clock every cycle, or pin rising edge  see R2
    tick   = ctl[CTL_EXT_CLK] ? rise : 1'b1;
    reload = (count == cmpVal);
    hitNxt = 1'b0;
    case (mode)
      MD_TIMER, MD_WDOG, MD_EVENT: hitNxt = run & tick & reload;  // see R3 see R4
      MD_PWM:                      begin
        reload = &count;
        hitNxt = run & tick & reload;
      end
      MD_MEAS:                     hitNxt = run & fall;
      default:                     hitNxt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinPrev <= 1'b0;
    end else if (ce && !stop) begin
      pinPrev <= pinLvl;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= WORD_RST;
    end else if (ce) begin
      if (!ctl[CTL_EN]) begin
        count <= loadVal;
      end else if (run) begin
        if (mode == MD_MEAS) begin
          // Measure high time of the pin in internal clocks  see R5
          if (fall) begin
            count <= loadVal;
          end else if (pinLvl) begin
            count <= count + 1'b1;
          end
        end else if (mode != MD_GPIO && tick) begin
          count <= reload ? loadVal : count + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture <= WORD_RST;
    end else if (ce && run && mode == MD_MEAS && fall) begin
      capture <= count;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit <= 1'b0;
    end else if (ce) begin
      hit <= hitNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin level and direction; reset leaves it an undriven input  see R7 see R12
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'b0;
    end else if (ce && !stop) begin
      case (mode)
        MD_TIMER: pinOut <= ctl[CTL_EN] ? pinOut ^ hitNxt : 1'b0;  // see R4
        MD_PWM:   pinOut <= ctl[CTL_EN] & (count >= cmpVal);
        MD_WDOG:  pinOut <= ctl[CTL_EN] & (pinOut | hitNxt);
        MD_GPIO:  pinOut <= ctl[CTL_GPIO_VAL];                     // see R8
        default:  pinOut <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOe <= 1'b0;
    end else if (ce) begin
      if (stop) begin
        // Outputs float in stop, inputs stay inputs  see R10 see R9
        pinOe <= 1'b0;
      end else begin
        case (mode)
          MD_TIMER, MD_PWM, MD_WDOG: pinOe <= 1'b1;                // see R6
          MD_EVENT, MD_MEAS:         pinOe <= 1'b0;                // see R5
          MD_GPIO:                   pinOe <= ctl[CTL_GPIO_DIR];   // see R8
          default:                   pinOe <= 1'b0;
        endcase
      end
    end
  end

endmodule // ttp_channel

// *** src/ttp_triple_timer.sv ***
// Triple timer top: AXI4-Lite register file, pin synchronisers, interrupts
//
// Behaviour
// R1: Three identical independent channels, each with own pin and control register.
// R2: Each channel counts internal clock or external pin clock, as configured.
// R3: Channel raises an interrupt after counting the programmed number of events.
// R4: Channel drives its pin toward a device after programmed internal count.
// R5: Event counter and measurement modes use the pin as sampled input.
// R6: Watchdog, timer and pulse modulation modes drive the pin as output.
// R7: After reset every pin is a general-purpose input.
// R8: Control register writes make the pin a GPIO output or timer pin.
// R9: In stop, a pin that was an input stays an ignored input.
// R10: In stop, a pin that was an output goes high impedance.
// R11: Wait state leaves pin direction and level unchanged.
// R12: During reset each pin is an undriven, ignored input.
module ttp_triple_timer
  import ttp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Processor state
  input  wire logic              stopState,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Timer pins
  input  wire logic              timerPinCh0In,
  output logic                   timerPinCh0Out,
  output logic                   timerPinCh0Oe,
  input  wire logic              timerPinCh1In,
  output logic                   timerPinCh1Out,
  output logic                   timerPinCh1Oe,
  input  wire logic              timerPinCh2In,
  output logic                   timerPinCh2Out,
  output logic                   timerPinCh2Oe,
  // Interrupt
  output logic                   irq
);

  logic [CTL_W-1:0]  ctlR      [NUM_CH];
  logic [CNT_W-1:0]  loadR     [NUM_CH];
  logic [CNT_W-1:0]  cmpR      [NUM_CH];
  logic [CNT_W-1:0]  count     [NUM_CH];
  logic [CNT_W-1:0]  capture   [NUM_CH];
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] pinOut;
  logic [NUM_CH-1:0] pinOe;
  logic [NUM_CH-1:0] pinRaw;
  logic [NUM_CH-1:0] pinMeta_r;
  logic [NUM_CH-1:0] pinSync_r;
  logic [NUM_CH-1:0] irqStat_r;
  logic [NUM_CH-1:0] irqMask_r;
  logic [NUM_CH-1:0] irqClr;

  logic              awHeld_r;
  logic              wHeld_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [31:0]       wrData_r;
  logic [3:0]        wrStrb_r;
  logic              doWrite;
  logic              wrHit;

  ////////////////////////////////////////////////////////////////////////
  // Strobe merge of a write into an existing word
  function automatic logic [31:0] mergeW(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Byte address of one channel register
  function automatic logic [ADDR_W-1:0] chAddr(input int ch, input logic [7:0] ofs);
    return ADDR_W'(CH_STRIDE * ch) + ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; wait state is not an input here, so pins never see it  see R11
  assign pinRaw = {timerPinCh2In, timerPinCh1In, timerPinCh0In};
  // Only the second stage feeds logic, keeping metastability out

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else if (ce) begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channels, all alike and unconnected to each other  see R1
  for (genvar i = 0; i < NUM_CH; i++) begin : gCh
    ttp_channel uCh (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .stop    (stopState),
      .ctl     (ctlR[i]),
      .loadVal (loadR[i]),
      .cmpVal  (cmpR[i]),
      .pinLvl  (pinSync_r[i]),
      .count   (count[i]),
      .capture (capture[i]),
      .hit     (hit[i]),
      .pinOut  (pinOut[i]),
      .pinOe   (pinOe[i])
    );
  end

  // Drive and enable go out raw; the pad cell sits outside
  assign timerPinCh0Out = pinOut[0];
  assign timerPinCh0Oe  = pinOe[0];
  assign timerPinCh1Out = pinOut[1];
  assign timerPinCh1Oe  = pinOe[1];
  assign timerPinCh2Out = pinOut[2];
  assign timerPinCh2Oe  = pinOe[2];

  ////////////////////////////////////////////////////////////////////////
  // Write channels: address and data taken in either order
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
  assign doWrite       = awHeld_r & wHeld_r;

  // Address half waits here for the data half
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wrAddr_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        wrAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
    end
  end

  // Data half waits here for the address half
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wHeld_r  <= 1'b0;
      wrData_r <= WORD_RST;
      wrStrb_r <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r  <= 1'b1;
        wrData_r <= s_axi_wdata;
        wrStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Decode of every mapped write address, for the response only
  always_comb begin
    wrHit = (wrAddr_r == OFS_IRQ_STAT) || (wrAddr_r == OFS_IRQ_MASK);
    for (int i = 0; i < NUM_CH; i++) begin
      if (wrAddr_r == chAddr(i, OFS_CTL) || wrAddr_r == chAddr(i, OFS_LOAD) ||
          wrAddr_r == chAddr(i, OFS_CMP) || wrAddr_r == chAddr(i, OFS_CNT)) begin
        wrHit = 1'b1;
      end
    end
  end

  // Unmapped writes answer SLVERR and change nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel registers; count reads only
  // Writes land the edge after both halves are held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctlR[i]  <= CTL_RST;
        loadR[i] <= WORD_RST;
        cmpR[i]  <= WORD_RST;
      end
    end else if (ce && doWrite) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wrAddr_r == chAddr(i, OFS_CTL)) begin
          ctlR[i] <= CTL_W'(mergeW({25'h0, ctlR[i]}, wrData_r, wrStrb_r));  // see R8
        end
        if (wrAddr_r == chAddr(i, OFS_LOAD)) begin
          loadR[i] <= mergeW(loadR[i], wrData_r, wrStrb_r);
        end
        if (wrAddr_r == chAddr(i, OFS_CMP)) begin
          cmpR[i] <= mergeW(cmpR[i], wrData_r, wrStrb_r);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, write one to clear, new event beats the clear
  assign irqClr = (doWrite && wrAddr_r == OFS_IRQ_STAT && wrStrb_r[0]) ? wrData_r[NUM_CH-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat_r <= IRQ_RST;
    end else if (ce) begin
      irqStat_r <= (irqStat_r & ~irqClr) | hit;  // see R3
    end
  end

  // Mask write needs the low byte strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqMask_r <= IRQ_RST;
    end else if (ce && doWrite && wrAddr_r == OFS_IRQ_MASK && wrStrb_r[0]) begin
      irqMask_r <= wrData_r[NUM_CH-1:0];
    end
  end

  // Level output, high while any unmasked bit is set
  assign irq = |(irqStat_r & irqMask_r);  // see R3

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, data one cycle after address
  // No skid buffer: a new address waits until rready
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= WORD_RST;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        // Default answer for an unmapped address
        s_axi_rdata  <= WORD_RST;
        s_axi_rresp  <= RESP_SLVERR;
        if (s_axi_araddr == OFS_IRQ_STAT) begin
          s_axi_rdata[NUM_CH-1:0] <= irqStat_r;
          s_axi_rresp             <= RESP_OKAY;
        end
        if (s_axi_araddr == OFS_IRQ_MASK) begin
          s_axi_rdata[NUM_CH-1:0] <= irqMask_r;
          s_axi_rresp             <= RESP_OKAY;
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (s_axi_araddr == chAddr(i, OFS_CTL)) begin
            s_axi_rdata[CTL_W-1:0] <= ctlR[i];
            s_axi_rdata[STAT_PIN]  <= pinSync_r[i];
            s_axi_rdata[STAT_OE]   <= pinOe[i];
            s_axi_rresp            <= RESP_OKAY;
          end
          if (s_axi_araddr == chAddr(i, OFS_LOAD)) begin
            s_axi_rdata <= loadR[i];
            s_axi_rresp <= RESP_OKAY;
          end
          if (s_axi_araddr == chAddr(i, OFS_CMP)) begin
            s_axi_rdata <= cmpR[i];
            s_axi_rresp <= RESP_OKAY;
          end
          if (s_axi_araddr == chAddr(i, OFS_CNT)) begin
            // Measurement mode shows the last captured width
            s_axi_rdata <= (ctlR[i][CTL_MODE_LSB +: CTL_MODE_W] == MD_MEAS) ? capture[i] : count[i];
            s_axi_rresp <= RESP_OKAY;
          end
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ttp_triple_timer

// *** test/ttp_timer_properties.sv ***
// Concurrent checks on the triple timer ports
module ttp_timer_chk
  import ttp_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        stopState,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic        timerPinCh0Out,
  input wire logic        timerPinCh0Oe,
  input wire logic        timerPinCh1Out,
  input wire logic        timerPinCh1Oe,
  input wire logic        timerPinCh2Out,
  input wire logic        timerPinCh2Oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] oeAll;
  logic [2:0] outAll;
  assign oeAll = {timerPinCh2Oe, timerPinCh1Oe, timerPinCh0Oe};
  assign outAll = {timerPinCh2Out, timerPinCh1Out, timerPinCh0Out};
  ////////////////////////////////////////////////
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence wrBusy;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence stopHeld;
    $past(stopState) && $past(ce) && stopState;
  endsequence
  ////////////////////////////////////////////////
  chk_reset_pins_in: assert property ($past(rst) |-> oeAll == 3'h0)
    else $error("pin driven right after reset");
  chk_stop_tristate: assert property (stopHeld |-> oeAll == 3'h0)
    else $error("pin driven in stop");
  chk_stop_frozen: assert property (stopHeld |-> $stable(outAll))
    else $error("pin level moved in stop");
  chk_write_answer: assert property (wrBoth |=> wrBusy ##1 s_axi_bvalid)
    else $error("write answer late or early");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready && ce |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready && ce |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule  // ttp_timer_chk

bind ttp_triple_timer ttp_timer_chk u_ttp_timer_chk (.clk, .rst, .ce, .stopState, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .timerPinCh0Out, .timerPinCh0Oe, .timerPinCh1Out, .timerPinCh1Oe, .timerPinCh2Out, .timerPinCh2Oe);

// *** test/ttp_pin_partner.sv ***
// Far side of one timer pin: event source and load monitor
module ttp_pin_partner #(
  parameter int HIGH_LEN = 3
) (
  // Clock
  input  wire logic        clk,
  // Pin from the timer
  input  wire logic        pinOe,
  input  wire logic        pinOut,
  // Bench control
  input  wire logic        go,
  input  wire logic [7:0]  pulses,
  // Pin level and monitor
  output logic             pinLvl,
  output logic             busy,
  output logic      [15:0] seenRises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic srcLvl = 1'b0;
  logic prevHi = 1'b0;
  initial busy = 1'b0;
  initial seenRises = 16'h0;
  // An undriven pin reads the event source level, which idles low
  assign pinLvl = pinOe ? pinOut : srcLvl;
  // Low time exceeds the synchroniser depth
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      repeat (pulses) begin
        srcLvl <= 1'b1;
        repeat (HIGH_LEN) @(posedge clk);
        srcLvl <= 1'b0;
        repeat (4) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
  always @(posedge clk) begin
    prevHi <= pinOe && pinOut;
    if (pinOe && pinOut && !prevHi) seenRises <= seenRises + 16'h1;
  end
endmodule  // ttp_pin_partner

// *** test/triple_timer_pin_logic_bench.sv ***
// Register-level tests of the triple timer
module triple_timer_pin_logic_bench import ttp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, stopState = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pulseN = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  pinIn, pinOut, pinOe, busy, go = 3'h0;
  logic [15:0] rises [3];
  logic [31:0] rdv, cnt0;
  logic [1:0]  rsp;
  int          fail_count = 0, n_checks = 0;
  ttp_mode_t   mdTab [6] = '{MD_GPIO, MD_TIMER, MD_PWM, MD_WDOG, MD_EVENT, MD_MEAS};
  logic        oeTab [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0]  ofs [4] = '{OFS_CTL, OFS_LOAD, OFS_CMP, OFS_CNT};
  localparam logic [31:0] GPO_HI = (32'h1 << CTL_GPIO_DIR) | (32'h1 << CTL_GPIO_VAL);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////
  ttp_triple_timer u_ttp_triple_timer (.clk, .rst, .ce, .stopState, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerPinCh0In(pinIn[0]), .timerPinCh0Out(pinOut[0]),
    .timerPinCh0Oe(pinOe[0]), .timerPinCh1In(pinIn[1]), .timerPinCh1Out(pinOut[1]),
    .timerPinCh1Oe(pinOe[1]), .timerPinCh2In(pinIn[2]), .timerPinCh2Out(pinOut[2]),
    .timerPinCh2Oe(pinOe[2]), .irq);
  for (genvar i = 0; i < 3; i++) begin : g_far
    ttp_pin_partner u_ttp_pin_partner (.clk, .pinOe(pinOe[i]), .pinOut(pinOut[i]), .go(go[i]),
      .pulses(pulseN), .pinLvl(pinIn[i]), .busy(busy[i]), .seenRises(rises[i]));
  end
  ////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awOk, wOk;
    r = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      awOk = s_axi_awvalid && s_axi_awready;
      wOk = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
        return;
      end
      @(posedge clk);
      if (awOk) s_axi_awvalid <= 1'b0;
      if (wOk) s_axi_wvalid <= 1'b0;
    end
    check(32'h0, 32'h1, "write hang");
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arOk;
    d = 32'h0;
    r = 2'h3;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      arOk = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
        return;
      end
      @(posedge clk);
      if (arOk) s_axi_arvalid <= 1'b0;
    end
    check(32'h0, 32'h1, "read hang");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWr(a, d, r);
    check(32'(r), 32'(RESP_OKAY), "write resp");
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(a, d, r);
    check(d, exp, what);
    check(32'(r), 32'(RESP_OKAY), "read resp");
  endtask
  task automatic pulse(input int c, input logic [7:0] n);
    @(posedge clk);
    pulseN <= n;
    go[c] <= 1'b1;
    @(posedge clk);
    go[c] <= 1'b0;
    for (int k = 0; k < 2000 && (busy[c] || k < 2); k++) @(negedge clk);
  endtask
  function automatic logic [7:0] ra(input int c, input logic [7:0] o);
    return 8'(c) * CH_STRIDE + o;
  endfunction
  function automatic logic [31:0] mc(input ttp_mode_t m);
    return 32'h1 | (32'(m) << CTL_MODE_LSB);
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({28'h0, pinOe, irq}, 32'h0, "reset pins");
    for (int c = 0; c < 3; c++) foreach (ofs[k]) rdChk(ra(c, ofs[k]), WORD_RST, "reset value");
    rdChk(OFS_IRQ_MASK, WORD_RST, "reset mask");
    for (int c = 0; c < 3; c++) foreach (mdTab[k]) begin
      wr(ra(c, OFS_CTL), mc(mdTab[k]));
      repeat (2) @(negedge clk);
      check(32'(pinOe[c]), 32'(oeTab[k]), "mode direction");
    end
    // Channels turned to outputs one by one; earlier ones must stay put
    for (int c = 0; c < 3; c++) begin
      wr(ra(c, OFS_CTL), GPO_HI);
      repeat (2) @(negedge clk);
      check({26'h0, pinOe, pinOut}, {26'h0, 3'(7 >> (2 - c)), 3'(7 >> (2 - c))}, "gpio out");
    end
    wr(ra(1, OFS_CTL), 32'h1 << CTL_GPIO_DIR);
    repeat (2) @(negedge clk);
    check({29'h0, pinOut}, 32'h5, "gpio low");
    wr(OFS_IRQ_STAT, 32'h7);
    rdChk(OFS_IRQ_STAT, 32'h0, "status clear");
    wr(ra(0, OFS_CMP), 32'h3);
    wr(ra(0, OFS_CTL), mc(MD_TIMER));
    repeat (4) @(negedge clk);
    cnt0 = 32'(rises[0]);
    repeat (80) @(negedge clk);
    check(32'(rises[0]) - cnt0, 32'd10, "toggle rate");
    check(32'(irq), 32'h0, "irq unmasked");
    rdChk(OFS_IRQ_STAT, 32'h1, "timer status");
    wr(OFS_IRQ_MASK, 32'h2);
    check(32'(irq), 32'h0, "irq other mask");
    wr(OFS_IRQ_MASK, 32'h1);
    check(32'(irq), 32'h1, "irq raised");
    wr(ra(0, OFS_CTL), 32'h0);
    wr(OFS_IRQ_STAT, 32'h1);
    rdChk(OFS_IRQ_STAT, 32'h0, "w1c");
    check(32'(irq), 32'h0, "irq cleared");
    wr(OFS_IRQ_MASK, 32'h2);
    wr(ra(1, OFS_CMP), 32'h4);
    wr(ra(1, OFS_CTL), mc(MD_EVENT) | (32'h1 << CTL_EXT_CLK));
    pulse(1, 8'd4);
    repeat (8) @(negedge clk);
    check(32'(irq), 32'h0, "early hit");
    pulse(1, 8'd1);
    repeat (8) @(negedge clk);
    check(32'(irq), 32'h1, "event hit");
    rdChk(OFS_IRQ_STAT, 32'h2, "event status");
    wr(ra(0, OFS_CTL), mc(MD_TIMER));
    @(posedge clk);
    stopState <= 1'b1;
    repeat (2) @(negedge clk);
    check({29'h0, pinOe}, 32'h0, "stop pins");
    rdChk(ra(1, OFS_CNT), 32'h0, "stop count");
    pulse(1, 8'd3);
    rdChk(ra(1, OFS_CNT), 32'h0, "stop ignores pin");
    @(posedge clk);
    stopState <= 1'b0;
    repeat (2) @(negedge clk);
    check({29'h0, pinOe}, 32'h5, "pins restored");
    axiRd(8'h40, rdv, rsp);
    check(rdv, 32'h0, "unmapped data");
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    axiWr(8'h44, 32'hffff_ffff, rsp);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    check(32'h0, 32'h1, "watchdog");
    end_of_test();
  end
endmodule  // triple_timer_pin_logic_bench
